// ===== core/pet_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef PET_CONSTS_SVH
`define PET_CONSTS_SVH
`define PET_OFF_CTRL      8'h00
`define PET_OFF_PERIOD    8'h04
`define PET_OFF_EV1       8'h08
`define PET_OFF_EV2       8'h0c
`define PET_OFF_EV3       8'h10
`define PET_OFF_EV4       8'h14
`define PET_OFF_PHASE     8'h18
`define PET_OFF_SAMP1     8'h1c
`define PET_OFF_SAMP2     8'h20
`define PET_OFF_ADJ_A     8'h24
`define PET_OFF_ADJ_B     8'h28
`define PET_OFF_BLANK_A   8'h2c
`define PET_OFF_BLANK_B   8'h30
`define PET_OFF_DEAD      8'h34
`define PET_OFF_EVDIV     8'h38
`define PET_OFF_STATUS    8'h3c
`define PET_CTRL_EN       0
`define PET_CTRL_CLOSED   1
`define PET_CTRL_POL_A    2
`define PET_CTRL_POL_B    3
`define PET_CTRL_OS_LO    4
`define PET_CTRL_SYNC_EN  6
`define PET_CTRL_RST      32'h0000_0000
`define PET_PERIOD_RST    14'h0100
`define PET_BLANK_END_LO  16
`define PET_FAST_PER_PS   4000
`define PET_FINE_STEP_PS  250
`define PET_FINE_STEPS    (`PET_FAST_PER_PS / `PET_FINE_STEP_PS)
`define PET_SLOW_DIV      4
`endif

// ===== core/pet_pkg.sv
// types and shared arithmetic for the pulse generator
package pet_pkg;
  typedef logic [13:0] pet_cnt_t;
  typedef logic [17:0] pet_evt_t;
  typedef logic signed [16:0] pet_adj_t;
  typedef enum logic [1:0] {
    PET_IDLE = 2'b00,
    PET_RESP = 2'b01
  } pet_apb_e;
  // add a signed quarter-ns offset to an event, clamped to range
  function automatic pet_evt_t pet_add_adj(input pet_evt_t e,
                                           input pet_adj_t a);
    logic signed [19:0] s;
    s = $signed({2'b00, e}) + $signed({{3{a[16]}}, a});
    if (s < 0)
      return '0;
    else if (s > 20'sh3ffff)
      return '1;
    else
      return s[17:0];
  endfunction
endpackage

// ===== core/pet_ctl_if.sv
// carrier for slow tick and synchronised sync pulse
`timescale 1ns/100ps
interface pet_ctl_if;
  logic slow_tick;
  logic sync_pulse;
  modport div  (output slow_tick);
  modport syn  (output sync_pulse);
  modport core (input slow_tick, input sync_pulse);
endinterface

// ===== core/pet_clkdiv.sv
// divider giving the slow control clock enable
`timescale 1ns/100ps
`include "pet_consts.svh"
module pet_clkdiv #(
  parameter int DIV = `PET_SLOW_DIV
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // tick out
  pet_ctl_if.div    ctl
);
  logic [7:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q         <= 8'h00;
      ctl.slow_tick <= 1'b0;
    end else begin
      ctl.slow_tick <= (cnt_q == 8'(DIV - 1));
      cnt_q         <= (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule

// ===== core/pet_syncin.sv
// three-stage synchroniser and rising-edge pulse for the sync pin
`timescale 1ns/100ps
module pet_syncin (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and pulse
  input  wire logic sync_in,
  pet_ctl_if.syn    ctl
);
  logic s1_q, s2_q, s3_q, lvl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q           <= 1'b0;
      s2_q           <= 1'b0;
      s3_q           <= 1'b0;
      lvl_q          <= 1'b0;
      ctl.sync_pulse <= 1'b0;
    end else begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts only once stages two and three agree
      if (s2_q == s3_q)
        lvl_q <= s3_q;
      ctl.sync_pulse <= (s2_q == s3_q) && s3_q && !lvl_q;
    end
  end
endmodule

// ===== core/pet_top.sv
// pulse generator channel: time base, edge events, triggers, apb slave
// Overview of operation
// - duty becomes on time in quarter-ns steps
// - incoming sync pulse resets ramp counter
// - sync out when counter crosses phase
// - own 14-bit time base, programmable period
// - new period shadowed until period end
// - two outputs, shared period, dead time in closed loop
// - signed cycle adjust up to 65536 steps
// - per-output polarity selectable
// - event pulse for interrupt and converter start
// - counter in quarters equals sample value: trigger conversion
// - optional 2, 4 or 8 samples per period on sample trigger 1
// - phase count sets slave sync offset
// - period counted in fast clock cycles
// - events 2-4: coarse upper, fine low four
// - fine placement on events 2-4 only
// - edges from compare of events and counter
// - multi mode edge assignment of events
// - open loop uses only own registers
// - samples and blanking always from registers
// - blanking windows mask switching noise
// - oversample code 00,01,10,11 = 1,2,4,8
`timescale 1ns/100ps
`include "pet_consts.svh"
module pet_top #(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // compensator duty
  input  wire logic [23:0]   duty_in,
  input  wire logic          duty_valid,
  // synchronisation
  input  wire logic          sync_in,
  output logic               sync_out,
  // pulse outputs with fine step codes
  output logic               pwm_a,
  output logic               pwm_b,
  output logic [3:0]         fine_a,
  output logic [3:0]         fine_b,
  // triggers, blanking and events
  output logic               sample_trig1,
  output logic               sample_trig2,
  output logic               blank_a,
  output logic               blank_b,
  output logic               period_evt
);
  pet_ctl_if ctl ();
  pet_clkdiv #(.DIV(`PET_SLOW_DIV)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .ctl     (ctl.div)
  );
  pet_syncin u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .sync_in (sync_in),
    .ctl     (ctl.syn)
  );

  // software registers
  logic [31:0]       ctrl_q;
  pet_pkg::pet_cnt_t period_sh_q, period_q, ev1_q, phase_q;
  pet_pkg::pet_evt_t ev2_q, ev3_q, ev4_q, dead_q;
  logic [11:0]       samp1_q, samp2_q;
  pet_pkg::pet_adj_t adj_a_q, adj_b_q;
  logic [31:0]       blank_a_q, blank_b_q;
  logic [7:0]        evdiv_q;
  pet_pkg::pet_apb_e apb_q;
  // datapath state
  pet_pkg::pet_cnt_t cnt_q;
  logic [22:0]       duty_sh_q, duty_q;
  logic [40:0]       prod_q;
  logic              raw_a_q, raw_b_q;
  logic [11:0]       os_next_q;
  logic [3:0]        os_left_q;
  logic [7:0]        evcnt_q;

  wire en   = ctrl_q[`PET_CTRL_EN];
  wire wrap = (cnt_q >= period_q);
  wire acc  = psel && penable && pready;
  wire wr   = acc && pwrite;
  wire [7:0] a8 = 8'(paddr);

  // apb: answer registered at setup, done in one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_q   <= pet_pkg::PET_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      case (apb_q)
        pet_pkg::PET_IDLE: begin
          if (psel && !penable) begin
            apb_q   <= pet_pkg::PET_RESP;
            pready  <= 1'b1;
            pslverr <= (a8 > `PET_OFF_STATUS) || (a8[1:0] != 2'b00);
            prdata  <= rd_mux(a8);
          end
        end
        pet_pkg::PET_RESP: begin
          apb_q   <= pet_pkg::PET_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          apb_q  <= pet_pkg::PET_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `PET_OFF_CTRL:    return ctrl_q;
      `PET_OFF_PERIOD:  return {18'h0, period_sh_q};
      `PET_OFF_EV1:     return {18'h0, ev1_q};
      `PET_OFF_EV2:     return {14'h0, ev2_q};
      `PET_OFF_EV3:     return {14'h0, ev3_q};
      `PET_OFF_EV4:     return {14'h0, ev4_q};
      `PET_OFF_PHASE:   return {18'h0, phase_q};
      `PET_OFF_SAMP1:   return {20'h0, samp1_q};
      `PET_OFF_SAMP2:   return {20'h0, samp2_q};
      `PET_OFF_ADJ_A:   return {{15{adj_a_q[16]}}, adj_a_q};
      `PET_OFF_ADJ_B:   return {{15{adj_b_q[16]}}, adj_b_q};
      `PET_OFF_BLANK_A: return blank_a_q;
      `PET_OFF_BLANK_B: return blank_b_q;
      `PET_OFF_DEAD:    return {14'h0, dead_q};
      `PET_OFF_EVDIV:   return {24'h0, evdiv_q};
      `PET_OFF_STATUS:  return {12'h0, blank_b, blank_a, pwm_b, pwm_a,
                                2'b00, cnt_q};
      default:          return 32'h0000_0000;
    endcase
  endfunction

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= `PET_CTRL_RST;
      period_sh_q <= `PET_PERIOD_RST;
      ev1_q       <= '0;
      ev2_q       <= '0;
      ev3_q       <= '0;
      ev4_q       <= '0;
      phase_q     <= '0;
      samp1_q     <= '0;
      samp2_q     <= '0;
      adj_a_q     <= '0;
      adj_b_q     <= '0;
      blank_a_q   <= '0;
      blank_b_q   <= '0;
      dead_q      <= '0;
      evdiv_q     <= '0;
    end else if (wr) begin
      case (a8)
        `PET_OFF_CTRL:    ctrl_q      <= {25'h0, pwdata[6:0]};
        `PET_OFF_PERIOD:  period_sh_q <= pwdata[13:0];
        `PET_OFF_EV1:     ev1_q       <= pwdata[13:0];
        `PET_OFF_EV2:     ev2_q       <= pwdata[17:0];
        `PET_OFF_EV3:     ev3_q       <= pwdata[17:0];
        `PET_OFF_EV4:     ev4_q       <= pwdata[17:0];
        `PET_OFF_PHASE:   phase_q     <= pwdata[13:0];
        `PET_OFF_SAMP1:   samp1_q     <= pwdata[11:0];
        `PET_OFF_SAMP2:   samp2_q     <= pwdata[11:0];
        `PET_OFF_ADJ_A:   adj_a_q     <= pwdata[16:0];
        `PET_OFF_ADJ_B:   adj_b_q     <= pwdata[16:0];
        `PET_OFF_BLANK_A: blank_a_q   <= {2'b00, pwdata[29:16],
                                          2'b00, pwdata[13:0]};
        `PET_OFF_BLANK_B: blank_b_q   <= {2'b00, pwdata[29:16],
                                          2'b00, pwdata[13:0]};
        `PET_OFF_DEAD:    dead_q      <= pwdata[17:0];
        `PET_OFF_EVDIV:   evdiv_q     <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // sync reset has priority over counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_q <= '0;
    else if (!en || (ctl.sync_pulse && ctrl_q[`PET_CTRL_SYNC_EN]))
      cnt_q <= '0;
    else if (wrap)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 14'h0001;
  end

  // period and duty shadows load at period end
  // period held in fast clock cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q  <= `PET_PERIOD_RST;
      duty_sh_q <= '0;
      duty_q    <= '0;
    end else begin
      if (duty_valid)
        duty_sh_q <= duty_in[23] ? 23'h0 : duty_in[22:0];
      if (wrap || !en) begin
        period_q <= period_sh_q;
        duty_q   <= duty_sh_q;
      end
    end
  end

  // duty times period in sixteenths of a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prod_q <= '0;
    else
      prod_q <= {period_q, 4'h0} * duty_q;
  end

  // open loop ignores compensator; event mapping
  // closed loop B rises a dead time after A falls
  pet_pkg::pet_evt_t ev2_base, ev3_eff, ev2_eff, ev4_eff;
  always_comb begin
    ev2_base = ctrl_q[`PET_CTRL_CLOSED] ? prod_q[40:23] : ev2_q;
    ev2_eff  = pet_pkg::pet_add_adj(ev2_base, adj_a_q);
    ev4_eff  = pet_pkg::pet_add_adj(ev4_q, adj_b_q);
    ev3_eff  = ctrl_q[`PET_CTRL_CLOSED]
             ? pet_pkg::pet_add_adj(ev2_eff, {1'b0, dead_q[15:0]})
             : ev3_q;
  end

  // compare edges; event 1 coarse only
  // coarse field upper, fine code passed with the edge
  // polarity applied at the output flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_a_q <= 1'b0;
      raw_b_q <= 1'b0;
      pwm_a   <= 1'b0;
      pwm_b   <= 1'b0;
      fine_a  <= 4'h0;
      fine_b  <= 4'h0;
    end else begin
      if (!en) begin
        raw_a_q <= 1'b0;
        raw_b_q <= 1'b0;
      end else begin
        if (cnt_q == ev2_eff[17:4]) begin
          raw_a_q <= 1'b0;
          fine_a  <= ev2_eff[3:0];
        end else if (cnt_q == ev1_q) begin
          raw_a_q <= 1'b1;
          fine_a  <= 4'h0;
        end
        if (cnt_q == ev4_eff[17:4]) begin
          raw_b_q <= 1'b0;
          fine_b  <= ev4_eff[3:0];
        end else if (cnt_q == ev3_eff[17:4]) begin
          raw_b_q <= 1'b1;
          fine_b  <= ev3_eff[3:0];
        end
      end
      pwm_a <= raw_a_q ^ ctrl_q[`PET_CTRL_POL_A];
      pwm_b <= raw_b_q ^ ctrl_q[`PET_CTRL_POL_B];
    end
  end

  // sync out when counter reaches phase count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sync_out <= 1'b0;
    else
      sync_out <= en && (cnt_q == phase_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_a <= 1'b0;
      blank_b <= 1'b0;
    end else begin
      blank_a <= en && (cnt_q >= blank_a_q[13:0])
                    && (cnt_q < blank_a_q[29:16]);
      blank_b <= en && (cnt_q >= blank_b_q[13:0])
                    && (cnt_q < blank_b_q[29:16]);
    end
  end

  // compare on slow tick against counter in quarters
  // walk evenly spaced points, 2^code per period
  // each quarter value lasts four cycles, so one tick sees it once
  wire [1:0]  os_code = ctrl_q[`PET_CTRL_OS_LO+:2];
  wire [11:0] os_step = period_q[13:2] >> os_code;
  wire [11:0] cnt4    = cnt_q[13:2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_next_q    <= '0;
      os_left_q    <= '0;
      sample_trig1 <= 1'b0;
      sample_trig2 <= 1'b0;
    end else begin
      sample_trig1 <= 1'b0;
      sample_trig2 <= 1'b0;
      if (wrap || !en) begin
        os_next_q <= samp1_q;
        os_left_q <= 4'((5'h01 << os_code) - 5'h01);
      end else if (ctl.slow_tick) begin
        if (cnt4 == os_next_q) begin
          sample_trig1 <= 1'b1;
          if (os_left_q != 4'h0) begin
            os_next_q <= os_next_q + os_step;
            os_left_q <= os_left_q - 4'h1;
          end
        end
        sample_trig2 <= (cnt4 == samp2_q);
      end
    end
  end

  // period event divided for interrupt and converter start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evcnt_q    <= '0;
      period_evt <= 1'b0;
    end else begin
      period_evt <= 1'b0;
      if (en && wrap) begin
        if (evcnt_q >= evdiv_q) begin
          evcnt_q    <= '0;
          period_evt <= 1'b1;
        end else
          evcnt_q <= evcnt_q + 8'h01;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_WRAP: assert property (en && wrap |=> cnt_q == 14'h0)
    else $error("counter did not wrap at period");
  AST_SYNC_RST: assert property (
    ctl.sync_pulse && ctrl_q[`PET_CTRL_SYNC_EN] |=> cnt_q == 14'h0)
    else $error("sync pulse did not reset counter");
  AST_SYNC_OUT: assert property (
    en && cnt_q == phase_q |=> sync_out ##1 (!sync_out || $stable(cnt_q)))
    else $error("sync out missing at phase count");
  AST_SHADOW: assert property (
    $changed(period_q) |-> $past(wrap) || $past(!en))
    else $error("period changed mid period");
  AST_RISE_A: assert property (
    en && $past(en) && cnt_q == ev1_q && cnt_q != ev2_eff[17:4]
    |=> raw_a_q ##1 pwm_a == (1'b1 ^ $past(ctrl_q[`PET_CTRL_POL_A])))
    else $error("output A missed rising event");
  AST_FALL_A: assert property (
    en && cnt_q == ev2_eff[17:4] |=> !raw_a_q && fine_a == $past(ev2_eff[3:0]))
    else $error("output A missed falling event");
  AST_POL_B: assert property (
    pwm_b == ($past(raw_b_q) ^ $past(ctrl_q[`PET_CTRL_POL_B])))
    else $error("output B polarity wrong");
  AST_SAMPLE: assert property (
    sample_trig1 |-> $past(ctl.slow_tick) && $past(cnt4) == $past(os_next_q))
    else $error("sample trigger off its point");
  AST_OS_LEFT: assert property (
    $past(wrap || !en) |-> os_left_q == 4'((5'h01 << $past(os_code)) - 5'h01))
    else $error("sample point count not reloaded");
  AST_BLANK: assert property (
    blank_a |-> $past(cnt_q) >= $past(blank_a_q[13:0]))
    else $error("blanking A before its begin");

  COV_SYNC: cover property (ctl.sync_pulse ##1 cnt_q == 14'h0);
  COV_OS8:  cover property (os_code == 2'b11 && sample_trig1);
  COV_WR:   cover property (wr && a8 == `PET_OFF_PERIOD);
  COV_EVT:  cover property (period_evt && evdiv_q != 8'h00);
endmodule

// ===== bench/pet_partner.sv
// compensator and sync source model facing the pulse generator
`timescale 1ns/100ps
module pet_partner (
  // clock
  input  wire logic  pclk,
  // compensator duty
  output logic [23:0] duty_in,
  output logic        duty_valid,
  // external sync source
  output logic        sync_in
);
  initial begin
    duty_in = 24'h000000;
    duty_valid = 1'b0;
    sync_in = 1'b0;
  end
  // duty as fraction
  // one-cycle strobe; afterwards the bus carries junk, not the old duty
  task automatic send_duty(input logic [23:0] d);
    @(posedge pclk);
    duty_in <= d;
    duty_valid <= 1'b1;
    @(posedge pclk);
    duty_in <= ~d;
    duty_valid <= 1'b0;
  endtask
  // held four cycles so the pin synchroniser surely sees it
  task automatic sync_pulse();
    @(posedge pclk);
    sync_in <= 1'b1;
    repeat (4) @(posedge pclk);
    sync_in <= 1'b0;
  endtask
endmodule

// ===== bench/pwm_event_timebase_tb_top.sv
// self-checking bench for the pulse generator channel
`timescale 1ns/100ps
`include "pet_consts.svh"
module pwm_event_timebase_tb_top;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic [23:0] duty_in;
  logic        duty_valid, sync_in, sync_out, pwm_a, pwm_b;
  logic [3:0]  fine_a, fine_b;
  logic        sample_trig1, sample_trig2, blank_a, blank_b;
  logic        period_evt;
  int          n_fail, samples_checked, cyc;

  pet_top #(.AW(8)) i_pet_top (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .duty_in,
    .duty_valid, .sync_in, .sync_out, .pwm_a, .pwm_b, .fine_a,
    .fine_b, .sample_trig1, .sample_trig2, .blank_a, .blank_b,
    .period_evt);
  pet_partner i_pet_partner (.pclk, .duty_in, .duty_valid, .sync_in);

  always #4 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // called just after a rising edge; idles one cycle afterwards
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  function automatic logic s(input int k);
    case (k)
      0: s = pwm_a;
      1: s = pwm_b;
      2: s = period_evt;
      3: s = sync_out;
      4: s = sample_trig1;
      5: s = blank_a;
      6: s = blank_b;
      default: s = sample_trig2;
    endcase
  endfunction

  task automatic wait_sig(input int k, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (s(k) !== v && n < 3000);
    if (n >= 3000) begin
      n_fail++;
      complete_run();
    end
  endtask

  // high time, or with full set the gap between two rises
  task automatic meas(input int k, input bit full, output int len);
    len = 0;
    wait_sig(k, 1'b0);
    wait_sig(k, 1'b1);
    do begin
      @(posedge pclk);
      len++;
    end while (s(k) === 1'b1 && len < 3000);
    if (full)
      do begin
        @(posedge pclk);
        len++;
      end while (s(k) !== 1'b1 && len < 3000);
  endtask

  // two wraps so shadowed settings are surely live
  task automatic settle();
    repeat (2) begin
      wait_sig(2, 1'b0);
      wait_sig(2, 1'b1);
    end
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, `PET_OFF_PERIOD, 32'h0, q, e);
    chk(q, 32'h100);
    wr(`PET_OFF_EV2, 32'hffffffff);
    apb(1'b0, `PET_OFF_EV2, 32'h0, q, e);
    chk(q, 32'h3ffff);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_open();
    int n;
    wr(`PET_OFF_PERIOD, 32'h1f);
    wr(`PET_OFF_EV1, 32'h2);
    wr(`PET_OFF_EV2, 32'h50);
    wr(`PET_OFF_EV3, 32'h83);
    wr(`PET_OFF_EV4, 32'h145);
    i_pet_partner.send_duty(24'h400000);
    wr(`PET_OFF_CTRL, 32'h1);
    meas(2, 1'b1, n);
    chk(n, 32);
    meas(0, 1'b0, n);
    chk(n, 3);
    chk({28'h0, fine_a}, 32'h0);
    wait_sig(1, 1'b1);
    chk({28'h0, fine_b}, 32'h3);
    meas(1, 1'b0, n);
    chk(n, 12);
    chk({28'h0, fine_b}, 32'h5);
    $display("test open loop done");
  endtask

  task automatic t_pol_adj();
    int n;
    logic [31:0] q;
    logic        e;
    wr(`PET_OFF_ADJ_A, 32'h10);
    wr(`PET_OFF_ADJ_B, 32'hffffffe0);
    wr(`PET_OFF_CTRL, 32'h1 | (32'h1 << `PET_CTRL_POL_A));
    settle();
    meas(0, 1'b0, n);
    chk(n, 28);
    meas(1, 1'b0, n);
    chk(n, 10);
    apb(1'b0, `PET_OFF_ADJ_B, 32'h0, q, e);
    chk(q, 32'hffffffe0);
    wr(`PET_OFF_ADJ_A, 32'h0);
    wr(`PET_OFF_ADJ_B, 32'h0);
    wr(`PET_OFF_CTRL, 32'h1);
    $display("test polarity adjust done");
  endtask

  task automatic t_shadow();
    int n, t0;
    wait_sig(2, 1'b0);
    wait_sig(2, 1'b1);
    t0 = cyc;
    wr(`PET_OFF_PERIOD, 32'h3f);
    wait_sig(2, 1'b0);
    wait_sig(2, 1'b1);
    chk(cyc - t0, 32);
    meas(2, 1'b1, n);
    chk(n, 64);
    $display("test shadow period done");
  endtask

  task automatic t_sync();
    int n, t0, d;
    wr(`PET_OFF_PHASE, 32'h10);
    meas(3, 1'b1, n);
    chk(n, 64);
    for (int k = 0; k < 2; k++) begin
      wr(`PET_OFF_CTRL, 32'h1 | (32'(k) << `PET_CTRL_SYNC_EN));
      wait_sig(3, 1'b0);
      wait_sig(3, 1'b1);
      t0 = cyc;
      i_pet_partner.sync_pulse();
      wait_sig(3, 1'b0);
      wait_sig(3, 1'b1);
      d = cyc - t0;
      if (k == 0)
        chk(d, 64);
      else
        chk({31'h0, d >= 18 && d <= 28}, 32'h1);
    end
    $display("test sync done");
  endtask

  task automatic t_os();
    int n;
    wr(`PET_OFF_SAMP1, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(`PET_OFF_CTRL, 32'h1 | (32'(c) << `PET_CTRL_OS_LO));
      settle();
      n = 0;
      repeat (64) begin
        @(posedge pclk);
        n += int'(s(4) === 1'b1);
      end
      chk(n, 32'h1 << c);
    end
    $display("test oversample done");
  endtask

  task automatic t_closed();
    int n;
    wr(`PET_OFF_DEAD, 32'h20);
    wr(`PET_OFF_EV4, 32'h3e0);
    wr(`PET_OFF_CTRL, 32'h3);
    for (int k = 0; k < 2; k++) begin
      i_pet_partner.send_duty(k ? 24'h200000 : 24'h400000);
      settle();
      meas(0, 1'b0, n);
      chk(n, k ? 13 : 29);
      chk({28'h0, fine_a}, k ? 32'hc : 32'h8);
      meas(1, 1'b0, n);
      chk(n, k ? 45 : 29);
    end
    $display("test closed loop done");
  endtask

  // windows and second trigger ignore the loop mode
  task automatic t_blank();
    int n;
    wr(`PET_OFF_BLANK_A, 32'h000a0004);
    wr(`PET_OFF_BLANK_B, 32'h00200010);
    wr(`PET_OFF_SAMP2, 32'h5);
    settle();
    meas(5, 1'b0, n);
    chk(n, 6);
    meas(6, 1'b0, n);
    chk(n, 16);
    meas(7, 1'b1, n);
    chk(n, 64);
    $display("test blanking done");
  endtask

  task automatic t_evdiv();
    int n;
    wr(`PET_OFF_EVDIV, 32'h1);
    settle();
    meas(2, 1'b1, n);
    chk(n, 128);
    $display("test event divide done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({30'h0, pwm_a, pwm_b}, 32'h0);
    t_regs();
    t_open();
    t_pol_adj();
    t_shadow();
    t_sync();
    t_os();
    t_closed();
    t_blank();
    t_evdiv();
    complete_run();
  end
endmodule
